/* logic/loop_lock_event_ctrl.v */
// lock-status event, mode and register logic of the loop clock generator
//
// Summary of operation
// - auto mode: lock change raises interrupt request
// - flag sets regardless of enable bit
// - manual mode: no LOOP_IRQ request, flag reads zero; pending masked status still drives IRQ
// - vco select allowed while unlocked
// - wait state leaves generator untouched
// - stop kills oscillator, loop, outputs low
// - break clear enabled: clears stick
// - tracking status set within tracking tolerance
// - lock set within lock tolerance
// - acquisition needs fixed reference cycle count
// - lock needs second fixed cycle count
// - control register read or reset clears flag
// - manual mode: enable ignores writes, reads zero
// - lock read-only, zero in manual
`timescale 1ns/1ps
`default_nettype none
`include "loop_lock_regs.vh"
module loop_lock_event_ctrl #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] ACQ_CYCLES = `ACQ_COUNT,
  parameter [CNT_W-1:0] TRK_CYCLES = `TRK_COUNT
) (
  input wire CLK,
  input wire RST,
  input wire CE,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire REF_TICK,
  input wire TRK_TOL,
  input wire LOCK_TOL,
  input wire WAIT_STATE,
  input wire STOP_STATE,
  input wire BREAK_STATE,
  output reg OSC_EN,
  output reg LOOP_EN,
  output reg VCO_SEL,
  output reg CLK_OUT_EN,
  output reg LOOP_IRQ,
  output reg IRQ
);
  // pin-side inputs pass two flops first
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  wire tick_s = s2_r[0];
  wire trk_s = s2_r[1];
  wire lock_s = s2_r[2];
  wire stop_s = s2_r[4];
  wire brk_s = s2_r[5];
  reg tick_d_r;

  reg ie_r, flag_r, pon_r, bcs_r, auto_r, man_trk_r;
  reg break_clear_enable_r;
  reg lock_r;
  reg [1:0] ist_r, imask_r;

  // reset image of the control register; only the power-on bit is picked from it below
  localparam [7:0] LC_RST = `LC_RESET;

  wire tick_edge = tick_s & ~tick_d_r;
  wire loop_live = pon_r & ~stop_s;
  wire acq_done, lock_done;

  function sel;
    input [3:0] a;
    input [3:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      tick_d_r <= 1'b0;
    end else if (CE) begin
      s1_r <= {BREAK_STATE, STOP_STATE, WAIT_STATE, LOCK_TOL, TRK_TOL,
               REF_TICK};
      s2_r <= s1_r;
      tick_d_r <= tick_s;
    end
  end

  // acquisition qualifier then lock qualifier, chained
  sync_counter #(.WIDTH(CNT_W)) acq_cnt (
    .CLK(CLK),
    .RST(RST),
    .ce(CE),
    .clr(~auto_r | ~loop_live),
    .tick(tick_edge),
    .in_tol(trk_s),
    .target(ACQ_CYCLES),
    .done(acq_done)
  );

  sync_counter #(.WIDTH(CNT_W)) lock_cnt (
    .CLK(CLK),
    .RST(RST),
    .ce(CE),
    .clr(~auto_r | ~loop_live | ~acq_done),
    .tick(tick_edge),
    .in_tol(lock_s),
    .target(TRK_CYCLES),
    .done(lock_done)
  );

  wire lock_nxt = auto_r & lock_done;
  wire lock_chg = auto_r & (lock_nxt ^ lock_r);
  wire trk_rise = auto_r & acq_done & ~ist_r[`IST_TRK_BIT];
  // during a break with clear disabled, accesses must not disturb the flag
  wire clr_ok = ~brk_s | break_clear_enable_r;
  wire lc_rd = RD & sel(ADDR, `ADDR_LOOP_CTRL);
  wire lc_wr = WR & sel(ADDR, `ADDR_LOOP_CTRL);
  wire bw_wr = WR & sel(ADDR, `ADDR_BW_CTRL);
  wire is_wr = WR & sel(ADDR, `ADDR_IRQ_STAT);
  wire im_wr = WR & sel(ADDR, `ADDR_IRQ_MASK);
  wire md_wr = WR & sel(ADDR, `ADDR_MODE_CTRL);

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ie_r <= 1'b0;
      flag_r <= 1'b0;
      pon_r <= LC_RST[`LC_PON_BIT];
      bcs_r <= 1'b0;
      auto_r <= 1'b0;
      man_trk_r <= 1'b0;
      break_clear_enable_r <= 1'b0;
      lock_r <= 1'b0;
      ist_r <= 2'h0;
      imask_r <= 2'h0;
    end else if (CE) begin
      lock_r <= lock_nxt;
      // event set wins over the read clear
      if (!auto_r) begin
        flag_r <= 1'b0;
      end else if (lock_chg) begin
        flag_r <= 1'b1;
      end else if (lc_rd && clr_ok) begin
        flag_r <= 1'b0;
      end
      if (lc_wr) begin
        if (auto_r) begin
          ie_r <= WDATA[`LC_IE_BIT];
        end
        // no lock check on vco select, only the loop must be on
        bcs_r <= WDATA[`LC_BCS_BIT] & (pon_r | WDATA[`LC_PON_BIT]) &
                 (bcs_r | pon_r);
        pon_r <= WDATA[`LC_PON_BIT] | bcs_r;
      end else if (!auto_r) begin
        ie_r <= 1'b0;
      end
      if (bw_wr) begin
        auto_r <= WDATA[`BW_AUTO_BIT];
        if (!auto_r) begin
          man_trk_r <= WDATA[`BW_TRK_BIT];
        end
      end
      if (md_wr) begin
        break_clear_enable_r <= WDATA[`MODE_BREAK_CLEAR_ENABLE_BIT];
      end
      if (im_wr) begin
        imask_r <= WDATA[1:0];
      end
      if (lock_chg) begin
        ist_r[`IST_LOCKCHG_BIT] <= 1'b1;
      end else if (is_wr && clr_ok && WDATA[`IST_LOCKCHG_BIT]) begin
        ist_r[`IST_LOCKCHG_BIT] <= 1'b0;
      end
      if (trk_rise) begin
        ist_r[`IST_TRK_BIT] <= 1'b1;
      end else if (is_wr && clr_ok && WDATA[`IST_TRK_BIT]) begin
        ist_r[`IST_TRK_BIT] <= 1'b0;
      end
    end
  end

  // outputs; wait state has no input here on purpose
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      OSC_EN <= 1'b0;
      LOOP_EN <= 1'b0;
      VCO_SEL <= 1'b0;
      CLK_OUT_EN <= 1'b0;
      LOOP_IRQ <= 1'b0;
      IRQ <= 1'b0;
    end else if (CE) begin
      OSC_EN <= ~stop_s;
      LOOP_EN <= loop_live;
      VCO_SEL <= bcs_r & ~stop_s;
      CLK_OUT_EN <= ~stop_s;
      LOOP_IRQ <= flag_r & ie_r & auto_r;
      IRQ <= |(ist_r & imask_r);
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `ADDR_LOOP_CTRL: RDATA <= {ie_r & auto_r, flag_r & auto_r, pon_r,
                                     bcs_r, `LC_UNIMPL};
          `ADDR_BW_CTRL: RDATA <= {auto_r, lock_r & auto_r,
                                   auto_r ? acq_done : man_trk_r, 5'h00};
          `ADDR_IRQ_STAT: RDATA <= {6'h00, ist_r};
          `ADDR_IRQ_MASK: RDATA <= {6'h00, imask_r};
          `ADDR_MODE_CTRL: RDATA <= {7'h00, break_clear_enable_r};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // loop_lock_event_ctrl
`default_nettype wire

/* logic/loop_lock_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef LOOP_LOCK_REGS_VH
`define LOOP_LOCK_REGS_VH

`define ADDR_LOOP_CTRL 4'h0
`define ADDR_BW_CTRL 4'h1
`define ADDR_IRQ_STAT 4'h2
`define ADDR_IRQ_MASK 4'h3
`define ADDR_MODE_CTRL 4'h4

`define LC_IE_BIT 7
`define LC_FLAG_BIT 6
`define LC_PON_BIT 5
`define LC_BCS_BIT 4
`define LC_UNIMPL 4'hF

`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_TRK_BIT 5

`define MODE_BREAK_CLEAR_ENABLE_BIT 0

`define IST_LOCKCHG_BIT 0
`define IST_TRK_BIT 1

`define LC_RESET 8'h2F
`define BW_RESET 8'h00
`define MODE_RESET 8'h00

`define ACQ_COUNT 16'h0008
`define TRK_COUNT 16'h0004

`endif

/* logic/sync_counter.v */
// qualifying counter: counts consecutive reference ticks within tolerance
`timescale 1ns/1ps
`default_nettype none
module sync_counter #(
  parameter WIDTH = 16
) (
  input wire CLK,
  input wire RST,
  input wire ce,
  input wire clr,
  input wire tick,
  input wire in_tol,
  input wire [WIDTH-1:0] target,
  output reg done
);
  reg [WIDTH-1:0] cnt_r;

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (ce) begin
      if (clr || !in_tol) begin
        // any reference cycle out of tolerance restarts the window
        cnt_r <= {WIDTH{1'b0}};
        done <= 1'b0;
      end else if (tick && !done) begin
        if (cnt_r + {{(WIDTH-1){1'b0}}, 1'b1} >= target) begin
          done <= 1'b1;
        end
        cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // sync_counter
`default_nettype wire

/* verif/ref_source.sv */
// reference clock model standing in for the analog loop side
`timescale 1ns/1ps
`default_nettype none
module ref_source (
  input wire logic CLK,
  input wire logic run,
  output logic ref_clk
);
  logic [1:0] div_r = 2'h0;
  // stands still while the loop is off, like a dead oscillator would
  always @(posedge CLK) begin
    if (run)
      div_r <= div_r + 2'h1;
  end
  assign ref_clk = div_r[1];
endmodule // ref_source
`default_nettype wire

/* verif/loop_lock_properties.sv */
// port assertions for the loop lock event block
`timescale 1ns/1ps
`default_nettype none
module loop_lock_properties (
  input wire logic CLK, RST, CE, WR, RD, STOP_STATE, WAIT_STATE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA, RDATA,
  input wire logic OSC_EN, LOOP_EN, VCO_SEL, CLK_OUT_EN, LOOP_IRQ
);
  logic auto_r;
  wire [3:0] outs = {OSC_EN, LOOP_EN, VCO_SEL, CLK_OUT_EN};
  // shadow of the bandwidth mode bit, followed from bus writes
  always @(posedge CLK or posedge RST) begin
    if (RST)
      auto_r <= 1'b0;
    else if (CE && WR && ADDR == 4'h1)
      auto_r <= WDATA[7];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  stop_outputs_a:
    assert property (STOP_STATE [*4] |=> outs == 4'h0) else $error("stop");
  wait_keep_a:
    assert property ((!STOP_STATE && !WR) [*8] ##0 WAIT_STATE
      |=> $stable(outs))
    else $error("wait");
  // loop enable stands for a loop already powered, which vco select needs
  vco_sel_a:
    assert property (CE && WR && ADDR == 4'h0 && WDATA[5:4] == 2'h3
      && LOOP_EN && !STOP_STATE |-> ##[1:4] VCO_SEL)
    else $error("vco select");
  manual_read_a:
    assert property (RD && ADDR == 4'h0 && !auto_r |=> RDATA[7:6] == 2'h0)
    else $error("manual read");
  manual_quiet_a:
    assert property (!auto_r [*2] |-> !LOOP_IRQ) else $error("manual irq");
  lock_manual_a:
    assert property (RD && ADDR == 4'h1 && !auto_r |=> !RDATA[6])
    else $error("manual lock");
  irq_hold_a:
    assert property (LOOP_IRQ && !RD && !WR && !$past(RD) && !$past(WR)
      |=> LOOP_IRQ) else $error("irq drop");
  rdata_idle_a:
    assert property (!RD |=> RDATA == 8'h00) else $error("rdata idle");
  cover property ($rose(LOOP_IRQ));
  cover property ($rose(VCO_SEL));
  cover property (STOP_STATE [*4]);
endmodule // loop_lock_properties
`default_nettype wire

/* verif/loop_lock_event_ctrl_test.sv */
// self-checking bench for the loop lock event block
`timescale 1ns/1ps
`default_nettype none
`include "loop_lock_regs.vh"
module loop_lock_event_ctrl_test;
  logic CLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, TRK_TOL = 0, LOCK_TOL = 0;
  logic WAIT_STATE = 0, STOP_STATE = 0, BREAK_STATE = 0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, d;
  wire REF_TICK, OSC_EN, LOOP_EN, VCO_SEL, CLK_OUT_EN, LOOP_IRQ, IRQ;
  wire [7:0] RDATA;
  int n_errors = 0, checks_done = 0;
  always #2.5 CLK = ~CLK;
  ref_source ref_source_i (.CLK(CLK), .run(LOOP_EN), .ref_clk(REF_TICK));
  loop_lock_event_ctrl loop_lock_event_ctrl_i (.*);
  task test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task bit1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask
  task wirq(input logic v);
    int i;
    for (i = 0; i < 300 && LOOP_IRQ !== v; i++)
      @(posedge CLK) #1;
    bit1(LOOP_IRQ, v);
    if (i == 300)
      test_done;
  endtask
  task lock_cycle;
    realtime t0, tmin;
    WAIT_STATE <= 1'b1;
    wr(4'h1, 8'h80);
    t0 = $realtime;
    // one ref edge every four cycles of 5 ns
    tmin = (`ACQ_COUNT + `TRK_COUNT) * 20.0;
    TRK_TOL <= 1'b1;
    LOCK_TOL <= 1'b1;
    for (int i = 0; i < 100 && !d[6]; i++)
      rd(4'h1);
    chk(d, 8'hE0);
    if (!d[6])
      test_done;
    bit1($realtime - t0 >= tmin, 1'b1);
    bit1(LOOP_IRQ, 1'b0);
    rdc(4'h0, 8'h6F);
    rdc(4'h0, 8'h2F);
    wr(4'h0, 8'hA0);
    LOCK_TOL <= 1'b0;
    wirq(1'b1);
    rd(4'h1);
    bit1(d[6], 1'b0);
    rdc(4'h0, 8'hEF);
    wirq(1'b0);
    WAIT_STATE <= 1'b0;
  endtask
  task break_clear;
    // loop back on, auto mode, lock gained again sets the flag
    wr(4'h0, 8'h20);
    wr(4'h1, 8'h80);
    LOCK_TOL <= 1'b1;
    d = 8'h00;
    for (int i = 0; i < 100 && !d[6]; i++)
      rd(4'h1);
    bit1(d[6], 1'b1);
    if (!d[6])
      test_done;
    BREAK_STATE <= 1'b1;
    repeat (3) @(posedge CLK);
    rdc(4'h0, 8'h6F);
    wr(4'h0, 8'h20);
    rdc(4'h0, 8'h6F);
    wr(4'h4, 8'h01);
    rdc(4'h0, 8'h6F);
    rdc(4'h0, 8'h2F);
    BREAK_STATE <= 1'b0;
    repeat (3) @(posedge CLK);
    rdc(4'h0, 8'h2F);
  endtask
  task status_irq;
    bit1(IRQ, 1'b0);
    wr(4'h3, 8'h01);
    repeat (2) @(posedge CLK);
    #1 bit1(IRQ, 1'b1);
    wr(4'h2, 8'h01);
    repeat (2) @(posedge CLK);
    #1 bit1(IRQ, 1'b0);
    rdc(4'h2, 8'h02);
    rdc(4'hF, 8'h00);
  endtask
  task manual_stop;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'hB0);
    rdc(4'h0, 8'h3F);
    repeat (3) @(posedge CLK);
    #1 bit1(VCO_SEL, 1'b1);
    rdc(4'h1, 8'h00);
    STOP_STATE <= 1'b1;
    repeat (5) @(posedge CLK);
    #1 bit1(OSC_EN | LOOP_EN | VCO_SEL | CLK_OUT_EN, 1'b0);
    STOP_STATE <= 1'b0;
    // software parks the loop before wait: deselect, then power off
    wr(4'h0, 8'h20);
    wr(4'h0, 8'h00);
    repeat (3) @(posedge CLK);
    #1 bit1(LOOP_EN | VCO_SEL, 1'b0);
    rdc(4'h0, 8'h0F);
  endtask
  initial begin
    d = 8'h00;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    rdc(4'h0, 8'h2F);
    lock_cycle;
    status_irq;
    manual_stop;
    break_clear;
    test_done;
  end
endmodule // loop_lock_event_ctrl_test
bind loop_lock_event_ctrl loop_lock_properties loop_lock_properties_i (.*);
`default_nettype wire
